/* verilog/ahfs_axis_homing.sv */
`timescale 1ns/100ps
module ahfs_axis_homing #(
   parameter int STILL_CYCLES = ahfs_pkg::STILL_DEF
) (
   input  wire logic                          mclk_i,
   input  wire logic                          sys_rst_i,
   input  wire logic                          wb_cyc_i,
   input  wire logic                          wb_stb_i,
   input  wire logic                          wb_we_i,
   input  wire logic [ahfs_pkg::ADR_W-1:0]    wb_adr_i,
   input  wire logic [3:0]                    wb_sel_i,
   input  wire logic [31:0]                   wb_dat_i,
   output logic      [31:0]                   wb_dat_o,
   output logic                               wb_ack_o,
   input  wire logic                          stop_left_i,
   input  wire logic                          stop_right_i,
   input  wire logic                          home_i,
   input  wire logic                          enc_a_i,
   input  wire logic                          enc_b_i,
   input  wire logic                          drv_stall_i,
   input  wire logic                          drv_ot_i,
   input  wire logic                          drv_otpw_i,
   input  wire logic                          drv_s2g_a_i,
   input  wire logic                          drv_s2g_b_i,
   input  wire logic                          drv_ol_a_i,
   input  wire logic                          drv_ol_b_i,
   input  wire logic                          pos_dev_i,
   input  wire logic [ahfs_pkg::LOAD_W-1:0]   load_i,
   input  wire logic                          standby_zero_i,
   output logic                               step_o,
   output logic                               dir_o,
   output logic      [1:0]                    standstill_mode_o,
   output logic                               homing_busy_o
);
   import ahfs_pkg::*;

   function automatic logic [31:0] wmerge(input logic [31:0] o,
                                          input logic [31:0] n,
                                          input logic [3:0]  s);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            r[i*8 +: 8] = n[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [SPD_W-1:0] clamp_spd(input logic [31:0] v);
      return (v > 32'(SPD_MAX)) ? SPD_MAX : v[SPD_W-1:0];
   endfunction

   // pin synchronisers
   logic [SYN_W-1:0] pin_s;
   ahfs_sync #(.W(SYN_W)) u_sync (
      .mclk_i    (mclk_i),
      .sys_rst_i (sys_rst_i),
      .d_i       ({pos_dev_i, drv_ol_b_i, drv_ol_a_i, drv_s2g_b_i,
                   drv_s2g_a_i, drv_otpw_i, drv_ot_i, drv_stall_i,
                   enc_b_i, enc_a_i, home_i, stop_right_i,
                   stop_left_i}),
      .q_o       (pin_s)
   );
   wire left_s  = pin_s[0];
   wire right_s = pin_s[1];
   wire home_s  = pin_s[2];
   wire enc_a_s = pin_s[3];
   wire enc_b_s = pin_s[4];
   wire stall_s = pin_s[5];
   wire dev_s   = pin_s[12];

   // registers
   logic        [7:0]         mode_sel;
   logic        [SPD_W-1:0]   spd_coarse;
   logic        [SPD_W-1:0]   spd_fine;
   logic signed [31:0]        span_dist;
   logic signed [31:0]        prepos;
   logic signed [31:0]        span_ref;
   logic signed [31:0]        pos;
   logic signed [31:0]        enc_cnt;
   logic        [7:0]         enc_cfg;
   logic        [15:0]        fsteps;
   logic        [15:0]        enc_res;
   logic        [1:0]         still_beh;
   logic        [LOAD_W-1:0]  load_q;
   logic        [1:0]         merr;
   logic        [STILL_W-1:0] still_cnt;
   logic        [1:0]         enc_prev;
   logic                      hm_done;
   logic                      seek_dir;
   logic                      cross_seen;
   ahfs_state_t               st;

   // bus decode
   wire [7:0] idx   = wb_adr_i[ADR_W-1:2];
   wire       req   = wb_cyc_i & wb_stb_i;
   wire       rd_ev = req & ~wb_ack_o & ~wb_we_i;
   wire       wr_ev = req & wb_ack_o & wb_we_i;

   wire [7:0] drv_fault;
   assign drv_fault[DF_STALL] = pin_s[5];
   assign drv_fault[DF_OT]    = pin_s[6];
   assign drv_fault[DF_OTPW]  = pin_s[7];
   assign drv_fault[DF_S2G_A] = pin_s[8];
   assign drv_fault[DF_S2G_B] = pin_s[9];
   assign drv_fault[DF_OL_A]  = pin_s[10];
   assign drv_fault[DF_OL_B]  = pin_s[11];
   assign drv_fault[DF_STILL] =
      still_cnt == STILL_W'(STILL_CYCLES - 1);

   wire busy = st != H_IDLE;
   wire [31:0] rd_word =
      (idx == IX_MODE)    ? {24'h000000, mode_sel} :
      (idx == IX_COARSE)  ? 32'(spd_coarse) :
      (idx == IX_FINE)    ? 32'(spd_fine) :
      (idx == IX_SPAN)    ? span_dist :
      (idx == IX_PREPOS)  ? prepos :
      (idx == IX_ENC_CFG) ? {24'h000000, enc_cfg} :
      (idx == IX_FSTEPS)  ? {16'h0000, fsteps} :
      (idx == IX_STILL)   ? {30'h00000000, still_beh} :
      (idx == IX_LOAD)    ? 32'(load_q) :
      (idx == IX_MERR)    ? {30'h00000000, merr} :
      (idx == IX_DFLT)    ? {24'h000000, drv_fault} :
      (idx == IX_ENC)     ? enc_cnt :
      (idx == IX_ENC_RES) ? {16'h0000, enc_res} :
      (idx == IX_STAT)    ? {30'h00000000, hm_done, busy} :
      (idx == IX_POS)     ? pos :
                            32'h00000000;
   wire [31:0] wr_val = wmerge(rd_word, wb_dat_i, wb_sel_i);
   wire wr_ctrl = wr_ev & (idx == IX_CTRL);
   wire wr_enc  = wr_ev & (idx == IX_ENC);

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= req & ~wb_ack_o;
         if (req & ~wb_ack_o) begin
            wb_dat_o <= rd_word;
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         mode_sel   <= 8'h00;
         spd_coarse <= '0;
         spd_fine   <= '0;
         enc_cfg    <= 8'h00;
         fsteps     <= FSTEPS_RST;
         enc_res    <= 16'h0000;
         still_beh  <= 2'h0;
      end else if (wr_ev) begin
         if (idx == IX_MODE) mode_sel <= wr_val[7:0];
         if (idx == IX_COARSE) spd_coarse <= clamp_spd(wr_val);
         if (idx == IX_FINE) spd_fine <= clamp_spd(wr_val);
         if (idx == IX_ENC_CFG) enc_cfg <= wr_val[7:0];
         if (idx == IX_FSTEPS) fsteps <= wr_val[15:0];
         if (idx == IX_ENC_RES) enc_res <= wr_val[15:0];
         if (idx == IX_STILL) still_beh <= wr_val[1:0];
      end
   end

   // mode decode
   wire [3:0] mnum     = mode_sel[3:0];
   wire valid_mode     = (mode_sel[5:4] == 2'b00) &&
                         (mnum >= M_L) && (mnum <= M_H_NI);
   wire is_home        = (mnum >= M_H_NEG) && (mnum <= M_H_NI);
   wire use_right      = mode_sel[MB_RIGHT] & ~is_home;
   wire home_act       = home_s ^ (mode_sel[MB_INV] & is_home);
   wire ref_act        = is_home ? home_act
                                 : (use_right ? right_s : left_s);
   wire far_act        = use_right ? left_s : right_s;
   wire twin           = (mnum == M_R_L) || (mnum == M_R_LB);
   wire both           = (mnum == M_R_LB) || (mnum == M_LB);
   wire home_dir0      = (mnum == M_H_POS) || (mnum == M_H_PI);
   wire homing_run_command = wr_ctrl & wr_val[CB_RUN] &
                             valid_mode & ~busy;
   wire abort          = wr_ctrl & wr_val[CB_ABORT];
   wire moving         = busy & (st != H_ZERO);
   wire mv_dir         = (st == H_PRE) ? ~seek_dir : seek_dir;

   // step generator
   ahfs_step_if sif ();
   assign sif.run   = moving;
   assign sif.speed = ((st == H_PRE) || (st == H_SEEK))
                      ? spd_coarse : spd_fine;
   ahfs_step_gen u_gen (
      .mclk_i    (mclk_i),
      .sys_rst_i (sys_rst_i),
      .sif       (sif.gen)
   );
   wire step_ok = sif.step & moving;

   wire signed [31:0] span_diff = span_ref - pos;

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         st         <= H_IDLE;
         seek_dir   <= 1'b0;
         cross_seen <= 1'b0;
         span_ref   <= '0;
         span_dist  <= '0;
         prepos     <= '0;
         hm_done    <= 1'b0;
      end else if (abort && busy) begin
         st <= H_IDLE;
      end else begin
         unique case (st)
            H_IDLE: begin
               if (homing_run_command) begin
                  hm_done  <= 1'b0;
                  seek_dir <= is_home ? home_dir0 : use_right;
                  st       <= twin ? H_PRE : H_SEEK;
               end
            end
            H_PRE: begin
               if (far_act) begin
                  span_ref <= pos;
                  st       <= H_SEEK;
               end
            end
            H_SEEK: begin
               if (ref_act) begin
                  seek_dir <= ~seek_dir;
                  st       <= H_OFF;
               end else if (mnum == M_H_NEG && left_s) begin
                  seek_dir <= 1'b1;
               end else if (mnum == M_H_POS && right_s) begin
                  seek_dir <= 1'b0;
               end
            end
            H_OFF: begin
               cross_seen <= 1'b0;
               if (!ref_act) begin
                  if (both) begin
                     seek_dir <= ~seek_dir;
                     st       <= H_THRU;
                  end else begin
                     st <= H_ZERO;
                  end
               end
            end
            H_THRU: begin
               if (ref_act) begin
                  cross_seen <= 1'b1;
               end else if (cross_seen) begin
                  seek_dir <= ~seek_dir;
                  st       <= H_RET;
               end
            end
            H_RET: begin
               if (ref_act) begin
                  st <= H_ZERO;
               end
            end
            H_ZERO: begin
               prepos  <= pos;
               if (twin) begin
                  span_dist <= span_diff[31] ? -span_diff
                                             : span_diff;
               end
               hm_done <= 1'b1;
               st      <= H_IDLE;
            end
            default: st <= H_IDLE;
         endcase
      end
   end

   // position counter, zeroed at the switching point
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         pos <= '0;
      end else if (st == H_ZERO) begin
         pos <= '0;
      end else if (step_ok) begin
         pos <= mv_dir ? pos + 32'sd1 : pos - 32'sd1;
      end
   end

   // quadrature decode; a software write wins over a count
   wire [3:0] qv    = {enc_prev, enc_a_s, enc_b_s};
   wire       q_inc = (qv == 4'h1) || (qv == 4'h7) ||
                      (qv == 4'hE) || (qv == 4'h8);
   wire       q_dec = (qv == 4'h2) || (qv == 4'hB) ||
                      (qv == 4'hD) || (qv == 4'h4);
   wire       e_up  = enc_cfg[EC_INV] ? q_dec : q_inc;
   wire       e_dn  = enc_cfg[EC_INV] ? q_inc : q_dec;

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         enc_cnt  <= '0;
         enc_prev <= 2'b00;
      end else begin
         enc_prev <= {enc_a_s, enc_b_s};
         if (wr_enc) begin
            enc_cnt <= wr_val;
         end else if (e_up) begin
            enc_cnt <= enc_cnt + 32'sd1;
         end else if (e_dn) begin
            enc_cnt <= enc_cnt - 32'sd1;
         end
      end
   end

   // error flags: a new event wins over the clear
   wire [1:0] merr_set;
   assign merr_set[ME_STALL] = stall_s & moving;
   assign merr_set[ME_DEV]   = dev_s;
   wire merr_clr = (rd_ev & (idx == IX_MERR)) | homing_run_command;

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         merr      <= 2'b00;
         still_cnt <= '0;
         load_q    <= '0;
      end else begin
         merr   <= (merr & ~{2{merr_clr}}) | merr_set;
         load_q <= load_i;
         if (step_ok) begin
            still_cnt <= '0;
         end else if (!drv_fault[DF_STILL]) begin
            still_cnt <= still_cnt + STILL_W'(1);
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         step_o            <= 1'b0;
         dir_o             <= 1'b0;
         standstill_mode_o <= 2'b00;
         homing_busy_o     <= 1'b0;
      end else begin
         step_o            <= step_ok;
         dir_o             <= mv_dir;
         standstill_mode_o <= standby_zero_i ? still_beh : 2'b00;
         homing_busy_o     <= busy;
      end
   end
endmodule

/* inc/ahfs_pkg.sv */
package ahfs_pkg;
   localparam int CLK_HZ = 100_000_000;
   localparam int ADR_W  = 10;
   localparam int SPD_W  = 23;
   localparam int ACC_W  = 28;
   localparam int LOAD_W = 10;
   localparam int SYN_W  = 13;
   localparam int STILL_W = 21;
   localparam int STILL_DEF = 1 << 20;
   localparam logic [SPD_W-1:0] SPD_MAX = 23'h7A111E;

   // register indices, byte address is four times the index
   localparam logic [7:0] IX_MODE    = 8'hC1;
   localparam logic [7:0] IX_COARSE  = 8'hC2;
   localparam logic [7:0] IX_FINE    = 8'hC3;
   localparam logic [7:0] IX_SPAN    = 8'hC4;
   localparam logic [7:0] IX_PREPOS  = 8'hC5;
   localparam logic [7:0] IX_ENC_CFG = 8'hC9;
   localparam logic [7:0] IX_FSTEPS  = 8'hCA;
   localparam logic [7:0] IX_STILL   = 8'hCC;
   localparam logic [7:0] IX_LOAD    = 8'hCE;
   localparam logic [7:0] IX_MERR    = 8'hCF;
   localparam logic [7:0] IX_DFLT    = 8'hD0;
   localparam logic [7:0] IX_ENC     = 8'hD1;
   localparam logic [7:0] IX_ENC_RES = 8'hD2;
   localparam logic [7:0] IX_CTRL    = 8'hE0;
   localparam logic [7:0] IX_STAT    = 8'hE1;
   localparam logic [7:0] IX_POS     = 8'hE2;

   localparam logic [15:0] FSTEPS_RST = 16'h00C8;

   // mode value fields and codes
   localparam int MB_INV   = 7;
   localparam int MB_RIGHT = 6;
   localparam logic [3:0] M_L     = 4'h1;
   localparam logic [3:0] M_R_L   = 4'h2;
   localparam logic [3:0] M_R_LB  = 4'h3;
   localparam logic [3:0] M_LB    = 4'h4;
   localparam logic [3:0] M_H_NEG = 4'h5;
   localparam logic [3:0] M_H_POS = 4'h6;
   localparam logic [3:0] M_H_PI  = 4'h7;
   localparam logic [3:0] M_H_NI  = 4'h8;

   // control, status, encoder config, error and fault bits
   localparam int CB_RUN   = 0;
   localparam int CB_ABORT = 1;
   localparam int SB_BUSY  = 0;
   localparam int SB_DONE  = 1;
   localparam int EC_INV   = 0;
   localparam int ME_STALL = 0;
   localparam int ME_DEV   = 1;
   localparam int DF_STALL = 0;
   localparam int DF_OT    = 1;
   localparam int DF_OTPW  = 2;
   localparam int DF_S2G_A = 3;
   localparam int DF_S2G_B = 4;
   localparam int DF_OL_A  = 5;
   localparam int DF_OL_B  = 6;
   localparam int DF_STILL = 7;

   typedef enum logic [2:0] {
      H_IDLE = 3'b000,
      H_PRE  = 3'b001,
      H_SEEK = 3'b010,
      H_OFF  = 3'b011,
      H_THRU = 3'b100,
      H_RET  = 3'b101,
      H_ZERO = 3'b110
   } ahfs_state_t;
endpackage

/* inc/ahfs_step_if.sv */
`timescale 1ns/100ps
interface ahfs_step_if;
   import ahfs_pkg::*;
   logic             run;
   logic [SPD_W-1:0] speed;
   logic             step;
   modport ctl (output run, output speed, input step);
   modport gen (input run, input speed, output step);
endinterface

/* verilog/ahfs_sync.sv */
`timescale 1ns/100ps
module ahfs_sync #(
   parameter int W = 1
) (
   input  wire logic         mclk_i,
   input  wire logic         sys_rst_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         s1 <= '0;
         s2 <= '0;
      end else begin
         s1 <= d_i;
         s2 <= s1;
      end
   end

   assign q_o = s2;
endmodule

/* verilog/ahfs_step_gen.sv */
`timescale 1ns/100ps
module ahfs_step_gen (
   input  wire logic mclk_i,
   input  wire logic sys_rst_i,
   ahfs_step_if.gen  sif
);
   import ahfs_pkg::*;

   // phase accumulator: speed in pulses per second at CLK_HZ
   logic [ACC_W-1:0] acc;
   wire  [ACC_W-1:0] sum = acc + ACC_W'(sif.speed);
   wire              ovf = sum >= ACC_W'(CLK_HZ);

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i || !sif.run) begin
         acc      <= '0;
         sif.step <= 1'b0;
      end else begin
         sif.step <= ovf;
         acc      <= ovf ? sum - ACC_W'(CLK_HZ) : sum;
      end
   end
endmodule

/* dv/ahfs_switch_model.sv */
`timescale 1ns/100ps
module ahfs_switch_model #(
   parameter int L_OUT = -22,
   parameter int L_IN  = -20,
   parameter int R_IN  = 20,
   parameter int R_OUT = 22,
   parameter int H_LO  = 5,
   parameter int H_HI  = 8
) (
   input  wire logic mclk_i,
   input  wire logic sys_rst_i,
   input  wire logic step_i,
   input  wire logic dir_i,
   output logic      left_o,
   output logic      right_o,
   output logic      home_o,
   output int        pos_o
);
   // carriage follows the step pulses
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i)
         pos_o <= 0;
      else if (step_i)
         pos_o <= dir_i ? pos_o + 1 : pos_o - 1;
   end
   // narrow zones, so a run can pass through a switch
   assign left_o  = pos_o >= L_OUT && pos_o <= L_IN;
   assign right_o = pos_o >= R_IN && pos_o <= R_OUT;
   assign home_o  = pos_o >= H_LO && pos_o <= H_HI;
endmodule

/* dv/ahfs_axis_homing_assertions.sv */
`timescale 1ns/100ps
module ahfs_axis_homing_assertions
   import ahfs_pkg::*;
(
   input wire logic              mclk_i,
   input wire logic              sys_rst_i,
   input wire logic              wb_cyc_i,
   input wire logic              wb_stb_i,
   input wire logic              wb_we_i,
   input wire logic [ADR_W-1:0]  wb_adr_i,
   input wire logic [31:0]       wb_dat_o,
   input wire logic              wb_ack_o,
   input wire logic [LOAD_W-1:0] load_i,
   input wire logic              standby_zero_i,
   input wire logic              step_o,
   input wire logic [1:0]        standstill_mode_o,
   input wire logic              homing_busy_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_load_rd;
      s_req ##0 (!wb_we_i && wb_adr_i[9:2] == IX_LOAD);
   endsequence
   AST_ACK_ONE: assert property (s_req |=> wb_ack_o)
      else $error("ack missing after request");
   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   AST_ACK_CAUSE: assert property
      (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   AST_LOAD_READ: assert property
      (s_load_rd |=> wb_dat_o == {22'h0, $past(load_i, 2)})
      else $error("load readout wrong");
   AST_STEP_PULSE: assert property (step_o |=> !step_o)
      else $error("step pulse too long");
   AST_STEP_BUSY: assert property (step_o |-> homing_busy_o)
      else $error("step while idle");
   AST_STILL_OFF: assert property
      (!standby_zero_i |=> standstill_mode_o == 2'h0)
      else $error("standstill mode without zero standby");
   AST_RST_QUIET: assert property (disable iff (1'b0)
      $fell(sys_rst_i) |-> !wb_ack_o && !step_o && !homing_busy_o)
      else $error("outputs active after reset");
endmodule
bind ahfs_axis_homing ahfs_axis_homing_assertions u_chk (
   .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .load_i(load_i),
   .standby_zero_i(standby_zero_i), .step_o(step_o),
   .standstill_mode_o(standstill_mode_o), .homing_busy_o(homing_busy_o));

/* dv/ahfs_axis_homing_tb.sv */
`timescale 1ns/100ps
module ahfs_axis_homing_tb;
   import ahfs_pkg::*;
   logic        mclk_i    = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic        cyc       = 1'b0;
   logic        we        = 1'b0;
   logic [9:0]  adr       = 10'h000;
   logic [31:0] wdat      = 32'h0;
   logic [31:0] rdat;
   logic [31:0] dout;
   logic        ack;
   logic        dev       = 1'b0;
   logic        sbz       = 1'b0;
   logic [6:0]  flt       = 7'h00;
   logic [1:0]  enc       = 2'h0;
   logic [9:0]  ld        = 10'h3FF;
   logic [1:0]  qs[4]     = '{2'h1, 2'h3, 2'h2, 2'h0};
   logic        sl, sr, hm, stp, dir, busy;
   logic [1:0]  smode;
   int          mpos;
   int          err_total = 0;
   int          compares  = 0;
   logic [7:0]  rix[11] = '{8'hC2, 8'hC3, 8'hCA, 8'hD2, 8'hD1, 8'hCC,
                            8'hCE, 8'hC5, 8'hE2, 8'hC0, 8'hC9};
   logic [31:0] rwd[11] = '{32'hFFFFFF, 32'h7A111F, 32'hFFFF, 32'hFFFF,
                            32'h80000001, 3, 1, 5, 7, 9, 1};
   logic [31:0] rrv[11] = '{0, 0, 32'hC8, 0, 0, 0, 32'h3FF, 0, 0, 0, 0};
   logic [31:0] rex[11] = '{32'h7A111E, 32'h7A111E, 32'hFFFF, 32'hFFFF,
                            32'h80000001, 3, 32'h3FF, 0, 0, 0, 1};
   logic [7:0]  md[10]  = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h41, 8'h08,
                            8'h05, 8'h06, 8'h07, 8'h88};
   int          cap[10] = '{-19, -19, -22, -22, 19, -10, 4, 4, 4, 5};
   int          spn[10] = '{0, 39, 42, 0, 0, 0, 0, 0, 0, 0};
   always #5 mclk_i = ~mclk_i;
   ahfs_axis_homing #(.STILL_CYCLES(64)) u_dut (
      .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
      .wb_dat_i(wdat), .wb_dat_o(dout), .wb_ack_o(ack),
      .stop_left_i(sl), .stop_right_i(sr), .home_i(hm),
      .enc_a_i(enc[1]), .enc_b_i(enc[0]), .drv_stall_i(flt[0]),
      .drv_ot_i(flt[1]), .drv_otpw_i(flt[2]), .drv_s2g_a_i(flt[3]),
      .drv_s2g_b_i(flt[4]), .drv_ol_a_i(flt[5]), .drv_ol_b_i(flt[6]),
      .pos_dev_i(dev), .load_i(ld), .standby_zero_i(sbz),
      .step_o(stp), .dir_o(dir), .standstill_mode_o(smode),
      .homing_busy_o(busy));
   ahfs_switch_model u_sw (
      .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .step_i(stp), .dir_i(dir),
      .left_o(sl), .right_o(sr), .home_o(hm), .pos_o(mpos));
   task automatic print_verdict;
      if (err_total == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge mclk_i);
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      compares++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] ix,
                     input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk_i);
      cyc <= 1'b1;
      we <= w;
      adr <= {ix, 2'b00};
      wdat <= d;
      do begin
         @(posedge mclk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (n >= 50) begin
         err_total++;
         print_verdict;
      end
      rdat = dout;
      cyc <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] ix, input logic [31:0] e);
      wb(1'b0, ix, 32'h0);
      chk($sformatf("register %h", ix), e, rdat);
   endtask
   task automatic dev_pulse;
      dev <= 1'b1;
      tick(1);
      dev <= 1'b0;
      tick(4);
   endtask
   task automatic rst;
      sys_rst_i <= 1'b1;
      tick(3);
      sys_rst_i <= 1'b0;
      wb(1'b1, IX_COARSE, 32'h4C4B40);
      wb(1'b1, IX_FINE, 32'hF4240);
   endtask
   // stall pulse mid-run when s is set
   task automatic home(input logic [7:0] m, input logic s);
      int n;
      dev_pulse;
      wb(1'b1, IX_MODE, {24'h0, m});
      wb(1'b1, IX_CTRL, 32'h1);
      tick(3);
      n = 0;
      while (busy === 1'b1 && n < 20000) begin
         flt[0] <= s && n == 60;
         tick(1);
         n++;
      end
      if (n >= 20000) begin
         err_total++;
         print_verdict;
      end
   endtask
   initial begin
      tick(3);
      sys_rst_i <= 1'b0;
      for (int i = 0; i < 11; i++) begin
         rd(rix[i], rrv[i]);
         wb(1'b1, rix[i], rwd[i]);
         rd(rix[i], rex[i]);
      end
      sbz <= 1'b1;
      tick(3);
      chk("standstill mode", 32'h3, {30'h0, smode});
      sbz <= 1'b0;
      // four quadrature edges forward, then four back; count inverted
      for (int i = 0; i < 8; i++) begin
         enc <= qs[i < 4 ? i : (10 - i) % 4];
         tick(4);
         if (i == 3)
            rd(IX_ENC, 32'h7FFFFFFD);
      end
      rd(IX_ENC, 32'h80000001);
      ld <= 10'h155;
      tick(2);
      rd(IX_LOAD, 32'h155);
      for (int i = 0; i < 7; i++) begin
         flt <= 7'(1 << i);
         tick(80);
         rd(IX_DFLT, 32'h80 | (1 << i));
      end
      flt <= 7'h00;
      dev_pulse;
      rd(IX_MERR, 32'h2);
      rd(IX_MERR, 32'h0);
      rst;
      wb(1'b1, IX_CTRL, 32'h1);
      tick(3);
      chk("busy on bad mode", 32'h0, {31'h0, busy});
      for (int i = 0; i < 10; i++) begin
         if (i != 5)
            rst;
         home(md[i], i == 0);
         rd(IX_PREPOS, 32'(cap[i]));
         rd(IX_POS, 32'h0);
         rd(IX_SPAN, 32'(spn[i]));
         rd(IX_MERR, {31'h0, i == 0});
         rd(IX_DFLT, 32'h0);
         rd(IX_STAT, 32'h2);
         chk("model pos", 32'(cap[i] + (i == 5 ? 19 : 0)), mpos);
      end
      // abort in mid-search leaves idle without the done bit
      rst;
      wb(1'b1, IX_MODE, 32'h1);
      wb(1'b1, IX_CTRL, 32'h1);
      tick(5);
      rd(IX_STAT, 32'h1);
      wb(1'b1, IX_CTRL, 32'h2);
      rd(IX_STAT, 32'h0);
      print_verdict;
   end
endmodule
